//--- hdl/dse_pkg.sv
// constants and carrier types for the decrement execution block
package dse_pkg;
  localparam int dse_word_width = 14;
  localparam int dse_data_width = 8;
  localparam int dse_addr_width = 7;
  localparam int dse_file_depth = 128;
  localparam logic [3:0] dse_opc_decrement = 4'h3;
  localparam logic [3:0] dse_opc_decrement_skip = 4'hb;
  localparam logic [1:0] dse_top_bits = 2'h0;
  localparam int dse_opc_msb = 11;
  localparam int dse_opc_lsb = 8;
  localparam int dse_dest_bit = 7;
  localparam logic [7:0] dse_zero_data = 8'h00;
  localparam logic [7:0] dse_one_data = 8'h01;
  localparam logic dse_dest_w = 1'h0;

  typedef enum logic [1:0] {
    quarter_phase_one = 2'b00,
    quarter_phase_two = 2'b01,
    quarter_phase_three = 2'b10,
    quarter_phase_four = 2'b11
  } dse_phase_type;

  typedef enum logic [1:0] {
    dse_op_none = 2'b00,
    decrement_file_op = 2'b01,
    decrement_skip_zero_op = 2'b10
  } dse_op_type;

  typedef struct packed {
    logic [6:0] addr;
    logic we;
    logic [7:0] wdata;
  } dse_file_port_type;

  typedef struct packed {
    dse_phase_type phase;
    dse_op_type op;
    logic dest_file;
    logic [6:0] addr;
    logic [7:0] result;
    logic skip_pending;
    logic skipping;
    logic [7:0] work;
    logic zero_flag;
    logic [7:0] file_we_data;
    logic file_we;
    logic [6:0] file_addr;
    logic fetch;
    logic busy_nop;
  } dse_state_type;
endpackage

//--- hdl/dse_file_mem.sv
// file register memory with registered read data
`timescale 1ns/1ps
module dse_file_mem
  import dse_pkg::*;
(
  input wire logic clock,
  input wire dse_file_port_type port,
  output logic [7:0] rdata
);
  // contents start cleared so the first decrement of any address is defined
  logic [7:0] mem [dse_file_depth] = '{default: dse_zero_data};

  always_ff @(posedge clock) begin
    if (port.we) begin
      mem[port.addr] <= port.wdata;
    end
    rdata <= mem[port.addr];
  end
endmodule

//--- hdl/dse_exec.sv
// four-phase execution of the decrement and decrement-and-skip instructions
`timescale 1ns/1ps
// Operation
// - opcode 0011 decrements a file register at 7-bit address, one cycle
// - destination bit 0 writes working register, 1 the file register
// - decode, read, compute and write fall in phases one to four
// - opcode 1011 decrements the file register with the same field layout
// - skip form routes the result by the destination bit likewise
// - nonzero result: next instruction runs, one cycle taken
// - zero result: next instruction discarded, two cycles taken
// - the discarded cycle reads, computes and writes nothing
module dse_exec
  import dse_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [13:0] instr,
  input wire logic instr_valid,
  output logic [7:0] work_reg,
  output logic zero_flag,
  output logic [1:0] phase,
  output logic fetch_next,
  output logic skip_cycle
);
  dse_state_type st;
  dse_state_type next_st;
  dse_file_port_type mem_port;
  logic [7:0] rdata;

  function automatic logic [7:0] dse_dec(input logic [7:0] v);
    dse_dec = v - dse_one_data;
  endfunction

  dse_file_mem u_mem (
    .clock(clock),
    .port(mem_port),
    .rdata(rdata)
  );

  // memory address follows the decoded address so data is ready by phase three
  always_comb begin
    mem_port.addr = st.file_we ? st.file_addr : st.addr;
    mem_port.we = st.file_we;
    mem_port.wdata = st.file_we_data;
  end

  always_comb begin
    next_st = st;
    next_st.file_we = 1'b0;
    next_st.fetch = 1'b0;
    unique case (st.phase)
      quarter_phase_one: begin
        next_st.phase = quarter_phase_two;
        next_st.op = dse_op_none;
        next_st.busy_nop = st.skip_pending;
        next_st.skipping = st.skip_pending;
        next_st.skip_pending = 1'b0;
        // discarded cycle decodes nothing
        if (!st.skip_pending && instr_valid &&
            instr[dse_word_width-1:dse_opc_msb+1] == dse_top_bits) begin
          next_st.addr = instr[dse_addr_width-1:0];
          next_st.dest_file = instr[dse_dest_bit];
          if (instr[dse_opc_msb:dse_opc_lsb] == dse_opc_decrement) begin
            next_st.op = decrement_file_op;
          end else if (instr[dse_opc_msb:dse_opc_lsb] ==
                       dse_opc_decrement_skip) begin
            next_st.op = decrement_skip_zero_op;
          end
        end
      end
      quarter_phase_two: begin
        // read is issued via the address; data registered for phase three
        next_st.phase = quarter_phase_three;
      end
      quarter_phase_three: begin
        next_st.phase = quarter_phase_four;
        if (st.op != dse_op_none && !st.busy_nop) begin
          next_st.result = dse_dec(rdata);
        end
      end
      quarter_phase_four: begin
        next_st.phase = quarter_phase_one;
        next_st.fetch = 1'b1;
        if (st.op != dse_op_none && !st.busy_nop) begin
          if (st.dest_file != dse_dest_w) begin
            next_st.file_we = 1'b1;
            next_st.file_addr = st.addr;
            next_st.file_we_data = st.result;
          end else begin
            next_st.work = st.result;
          end
          if (st.op == decrement_file_op) begin
            next_st.zero_flag = (st.result == dse_zero_data);
          end else begin
            // zero result costs a second cycle; nonzero runs on
            next_st.skip_pending = (st.result == dse_zero_data);
          end
        end
      end
    endcase
    if (next_st.phase == quarter_phase_one) begin
      next_st.skipping = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      work_reg <= dse_zero_data;
      zero_flag <= 1'b0;
      phase <= quarter_phase_one;
      fetch_next <= 1'b0;
      skip_cycle <= 1'b0;
    end else begin
      work_reg <= next_st.work;
      zero_flag <= next_st.zero_flag;
      phase <= next_st.phase;
      fetch_next <= next_st.fetch;
      skip_cycle <= next_st.skipping;
    end
  end
endmodule

//--- tb/dse_exec_sva.sv
// port assertions for the decrement execution block
`timescale 1ns/1ps
module dse_exec_sva
  import dse_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [13:0] instr,
  input wire logic instr_valid,
  input wire logic [7:0] work_reg,
  input wire logic zero_flag,
  input wire logic [1:0] phase,
  input wire logic fetch_next,
  input wire logic skip_cycle
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  phase_walk_a: assert property (phase == 2'h0 |=> phase == 2'h1
    ##1 phase == 2'h2 ##1 phase == 2'h3 ##1 phase == 2'h0) else $error("phase");
  fetch_pulse_a: assert property (fetch_next |->
    phase == 2'h0 ##1 !fetch_next) else $error("fetch");
  flag_keep_a: assert property (phase == 2'h0 &&
    !(instr_valid && instr[13:8] == 6'h03) |=> $stable(zero_flag)[*4])
    else $error("flag");
  work_keep_a: assert property (phase == 2'h0 && instr[7] |=>
    $stable(work_reg)[*4]) else $error("work dest");
  work_time_a: assert property ($changed(work_reg) |->
    phase == 2'h0) else $error("work time");
  skip_shape_a: assert property ($rose(skip_cycle) |->
    phase == 2'h1 ##1 skip_cycle[*2] ##1 !skip_cycle)
    else $error("skip shape");
  skip_quiet_a: assert property (skip_cycle |=>
    $stable(work_reg) && $stable(zero_flag)) else $error("skip quiet");
  skip_cause_a: assert property ($rose(skip_cycle) |->
    $past(instr_valid, 5) &&
    $past(instr[11:8], 5) == dse_opc_decrement_skip)
    else $error("skip cause");
endmodule
bind dse_exec dse_exec_sva chk_i (
  .clock(clock),
  .sys_rst(sys_rst),
  .instr(instr),
  .instr_valid(instr_valid),
  .work_reg(work_reg),
  .zero_flag(zero_flag),
  .phase(phase),
  .fetch_next(fetch_next),
  .skip_cycle(skip_cycle)
);

//--- tb/tb_decrement_skip_exec.sv
// self-checking bench for the decrement execution block
`timescale 1ns/1ps
module tb_decrement_skip_exec
  import dse_pkg::*;
;
  logic clock = 0, sys_rst = 1, instr_valid = 0;
  logic [13:0] instr = '0;
  logic [7:0] work_reg;
  logic [1:0] phase;
  logic zero_flag, fetch_next, skip_cycle;
  int failures = 0, n_compared = 0, cycles = 0;
  dse_exec dut (.clock(clock), .sys_rst(sys_rst), .instr(instr),
    .instr_valid(instr_valid), .work_reg(work_reg), .zero_flag(zero_flag),
    .phase(phase), .fetch_next(fetch_next), .skip_cycle(skip_cycle));
  initial forever #2.5 clock = ~clock;
  task end_sim;
    if (failures == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      failures++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  localparam logic [6:0] addr_a = 7'h15;
  localparam logic [6:0] addr_b = 7'h2a;
  function automatic logic [13:0] op_word(input logic [3:0] opc,
    input logic dest, input logic [6:0] addr);
    op_word = {dse_top_bits, opc, dest, addr};
  endfunction
  // one instruction cycle, presented just after the edge that starts it
  task issue(input logic [13:0] word);
    instr = word;
    instr_valid = 1'b1;
    repeat (4) @(posedge clock);
    #1;
  endtask
  // one instruction cycle, looking at the skip flag in phase two
  task issue_watch(input logic [13:0] word, input logic skip);
    instr = word;
    instr_valid = 1'b1;
    @(posedge clock);
    #1;
    chk(phase === 2'h1 && skip_cycle === skip, "skip flag");
    repeat (3) @(posedge clock);
    #1;
  endtask
  task check_reset;
    chk(work_reg === 8'h00 && zero_flag === 1'b0, "reset");
    chk(phase === 2'h0 && skip_cycle === 1'b0, "reset phase");
  endtask
  task other_op;
    issue(14'h0980);
    chk(work_reg === 8'h00, "other opcode");
  endtask
  task dec_to_work;
    issue(op_word(dse_opc_decrement, 1'b0, addr_a));
    chk(work_reg === 8'hff && zero_flag === 1'b0, "dec to w");
    chk(phase === 2'h0 && fetch_next === 1'b1, "one cycle");
  endtask
  // file registers start cleared, so 255 decrements leave 8'h01 behind
  task dec_to_file;
    repeat (255) issue(op_word(dse_opc_decrement, 1'b1, addr_a));
    chk(work_reg === 8'hff && zero_flag === 1'b0, "dec to f");
    issue(op_word(dse_opc_decrement, 1'b0, addr_a));
    chk(work_reg === 8'h00 && zero_flag === 1'b1, "zero flag");
  endtask
  task skip_not_taken;
    issue(op_word(dse_opc_decrement_skip, 1'b0, addr_b));
    chk(work_reg === 8'hff && zero_flag === 1'b1, "skip to w");
    issue_watch(op_word(dse_opc_decrement, 1'b0, addr_a), 1'b0);
    chk(work_reg === 8'h00 && zero_flag === 1'b1, "next runs");
  endtask
  task skip_taken;
    issue(op_word(dse_opc_decrement, 1'b0, addr_b));
    chk(work_reg === 8'hff && zero_flag === 1'b0, "flag clear");
    issue(op_word(dse_opc_decrement_skip, 1'b1, addr_a));
    chk(work_reg === 8'hff && zero_flag === 1'b0, "skip keeps");
    issue_watch(op_word(dse_opc_decrement, 1'b1, addr_a), 1'b1);
    chk(work_reg === 8'hff && skip_cycle === 1'b0, "discarded");
    issue(op_word(dse_opc_decrement, 1'b0, addr_a));
    chk(work_reg === 8'hff && zero_flag === 1'b0, "skip to f");
  endtask
  task reset_mid;
    sys_rst = 1'b1;
    repeat (2) @(posedge clock);
    #1 sys_rst = 1'b0;
    check_reset;
    issue(op_word(dse_opc_decrement, 1'b0, addr_b));
    chk(work_reg === 8'hff, "after reset");
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      end_sim;
    end
  end
  initial begin
    repeat (10) @(posedge clock);
    #1 sys_rst = 1'b0;
    check_reset;
    other_op;
    dec_to_work;
    dec_to_file;
    skip_not_taken;
    skip_taken;
    reset_mid;
    end_sim;
  end
endmodule
